//--- bpt_top.sv
// Purpose: bank phase timing trim store with AHB-Lite register access
// Assumes: factory trim inputs are stable once reset is released
// Notes:   trims load from the factory inputs at the first edge after reset
`timescale 1ns/1ps
`include "bpt_cfg.svh"
module bpt_top
  import bpt_pkg::*;
#(
  parameter int NUM_BANKS = `BPT_NUM_BANKS
)
(
  // Clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  // Converter side
  input  wire logic                      phase_m90,
  input  wire logic [NUM_BANKS-1:0][7:0] factory_trim0,
  input  wire logic [NUM_BANKS-1:0][7:0] factory_trim90,
  output logic      [NUM_BANKS-1:0][7:0] bank_trim
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Bank number sits in one index nibble, so sixteen is the ceiling
  if (NUM_BANKS < 1 || NUM_BANKS > `BPT_MAX_BANKS) begin : g_bad_banks
    $error("NUM_BANKS must be 1 to 16");
  end

  // ****************************************
  // Declarations
  // ****************************************
  bpt_reg_if                 regs ();
  bpt_phase_t                phase;
  logic                      loaded;
  logic                      next_loaded;
  logic [NUM_BANKS-1:0][7:0] trim0;
  logic [NUM_BANKS-1:0][7:0] trim90;
  logic [NUM_BANKS-1:0][7:0] next_trim0;
  logic [NUM_BANKS-1:0][7:0] next_trim90;

  // ****************************************
  // Decode helpers
  // ****************************************
  // Index 0x1N2 is bank N 0-degree, 0x1N3 bank N -90-degree
  function automatic logic trim_hit(logic [11:0] idx);
    return (idx[11:8] == `BPT_IDX_PAGE)
           && ((idx[3:0] == `BPT_OFS_PHASE0) || (idx[3:0] == `BPT_OFS_PHASE90))
           && (int'(idx[7:4]) < NUM_BANKS);
  endfunction

  function automatic bpt_trim_t read_trim(logic [11:0]               idx,
                                          logic [NUM_BANKS-1:0][7:0] t0,
                                          logic [NUM_BANKS-1:0][7:0] t90);
    bpt_trim_t v;
    v = `BPT_TRIM_RST;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (int'(idx[7:4]) == b) begin
        v = (idx[3:0] == `BPT_OFS_PHASE90) ? t90[b] : t0[b];
      end
    end
    return v;
  endfunction

  // ****************************************
  // Phase setting
  // ****************************************
  assign phase = phase_m90 ? BPT_PHASE_M90 : BPT_PHASE_0;

  // ****************************************
  // Trim storage
  // ****************************************
  always_comb begin
    next_loaded = 1'b1;
    next_trim0  = trim0;
    next_trim90 = trim90;
    if (!loaded) begin
      // Factory values are per device, so they are caught after reset release
      next_trim0  = factory_trim0;
      next_trim90 = factory_trim90;
    end else if (regs.wr_en && trim_hit(regs.wr_idx)) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (int'(regs.wr_idx[7:4]) == b) begin
          if (regs.wr_idx[3:0] == `BPT_OFS_PHASE90) begin
            next_trim90[b] = regs.wr_data;
          end else begin
            next_trim0[b] = regs.wr_data;
          end
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loaded <= 1'b0;
      trim0  <= '0;
      trim90 <= '0;
    end else begin
      loaded <= next_loaded;
      trim0  <= next_trim0;
      trim90 <= next_trim90;
    end
  end

  // ****************************************
  // Read back
  // ****************************************
  // Reading the next values lets a read right behind a write see the new data
  always_comb begin
    if (trim_hit(regs.rd_idx)) begin
      regs.rd_data = read_trim(regs.rd_idx, next_trim0, next_trim90);
    end else if (regs.rd_idx == `BPT_IDX_STATUS) begin
      regs.rd_data                   = 8'h00;
      regs.rd_data[`BPT_STAT_LOADED] = loaded;
      regs.rd_data[`BPT_STAT_PHASE]  = phase_m90;
    end else begin
      regs.rd_data = 8'h00;
    end
  end

  // ****************************************
  // Instances
  // ****************************************
  bpt_ahb_slave u_slave (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .regs      (regs)
  );

  bpt_trim_sel #(
    .NUM_BANKS (NUM_BANKS)
  ) u_sel (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .phase     (phase),
    .trim0     (trim0),
    .trim90    (trim90),
    .bank_trim (bank_trim)
  );

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_phase0_select: assert property (
    $past(phase_m90 == 1'b0) && $past(loaded) |-> bank_trim == $past(trim0))
    else $error("bank trim does not follow 0-degree value");

  a_phase90_select: assert property (
    $past(phase_m90 == 1'b1) && $past(loaded) |-> bank_trim == $past(trim90))
    else $error("bank trim does not follow -90-degree value");

  a_factory_load: assert property (
    $rose(loaded) |-> trim0 == $past(factory_trim0) && trim90 == $past(factory_trim90))
    else $error("factory trim not loaded after reset");

  a_write_readback: assert property (
    loaded && regs.wr_en && trim_hit(regs.wr_idx)
      |=> read_trim($past(regs.wr_idx), trim0, trim90) == $past(regs.wr_data))
    else $error("trim register does not hold written value");

  a_bank1_decode: assert property (
    loaded && regs.wr_en && regs.wr_idx == `BPT_IDX_BANK1_P90 && NUM_BANKS > 1
      |=> trim90[1] == $past(regs.wr_data) && trim0[1] == $past(trim0[1]))
    else $error("bank 1 -90-degree trim decoded wrongly");

  a_phase_follow: assert property (
    loaded && $changed(phase_m90) && !regs.wr_en
      |=> bank_trim == ($past(phase_m90) ? $past(trim90) : $past(trim0)))
    else $error("phase change did not switch trim selection");

  a_trim_stable: assert property (
    loaded && !regs.wr_en |=> trim0 == $past(trim0) && trim90 == $past(trim90))
    else $error("trim changed without a write");

  a_load_once: assert property (
    loaded |=> loaded)
    else $error("factory load repeated without reset");

  // ****************************************
  // Per-bank decode checks
  // ****************************************
  // A write lands in its own place only, the other half of the pair holds
  a_bank0_p0_decode: assert property (
    loaded && regs.wr_en && regs.wr_idx == `BPT_IDX_BANK0_P0
      |=> trim0[0] == $past(regs.wr_data) && trim90[0] == $past(trim90[0]))
    else $error("bank 0 0-degree trim decoded wrongly");

  a_bank0_p90_decode: assert property (
    loaded && regs.wr_en && regs.wr_idx == `BPT_IDX_BANK0_P90
      |=> trim90[0] == $past(regs.wr_data) && trim0[0] == $past(trim0[0]))
    else $error("bank 0 -90-degree trim decoded wrongly");

  a_bank1_p0_decode: assert property (
    loaded && regs.wr_en && regs.wr_idx == `BPT_IDX_BANK1_P0 && NUM_BANKS > 1
      |=> trim0[1] == $past(regs.wr_data) && trim90[1] == $past(trim90[1]))
    else $error("bank 1 0-degree trim decoded wrongly");

  a_bank2_p0_decode: assert property (
    loaded && regs.wr_en && regs.wr_idx == `BPT_IDX_BANK2_P0 && NUM_BANKS > 2
      |=> trim0[2] == $past(regs.wr_data) && trim90[2] == $past(trim90[2]))
    else $error("bank 2 0-degree trim decoded wrongly");

  a_bank2_p90_decode: assert property (
    loaded && regs.wr_en && regs.wr_idx == `BPT_IDX_BANK2_P90 && NUM_BANKS > 2
      |=> trim90[2] == $past(regs.wr_data) && trim0[2] == $past(trim0[2]))
    else $error("bank 2 -90-degree trim decoded wrongly");

  a_bank3_p0_decode: assert property (
    loaded && regs.wr_en && regs.wr_idx == `BPT_IDX_BANK3_P0 && NUM_BANKS > 3
      |=> trim0[3] == $past(regs.wr_data) && trim90[3] == $past(trim90[3]))
    else $error("bank 3 0-degree trim decoded wrongly");

  a_bank3_p90_decode: assert property (
    loaded && regs.wr_en && regs.wr_idx == `BPT_IDX_BANK3_P90 && NUM_BANKS > 3
      |=> trim90[3] == $past(regs.wr_data) && trim0[3] == $past(trim0[3]))
    else $error("bank 3 -90-degree trim decoded wrongly");

  a_bank4_p0_decode: assert property (
    loaded && regs.wr_en && regs.wr_idx == `BPT_IDX_BANK4_P0 && NUM_BANKS > 4
      |=> trim0[4] == $past(regs.wr_data) && trim90[4] == $past(trim90[4]))
    else $error("bank 4 0-degree trim decoded wrongly");

  a_bank4_p90_decode: assert property (
    loaded && regs.wr_en && regs.wr_idx == `BPT_IDX_BANK4_P90 && NUM_BANKS > 4
      |=> trim90[4] == $past(regs.wr_data) && trim0[4] == $past(trim0[4]))
    else $error("bank 4 -90-degree trim decoded wrongly");

  // ****************************************
  // Read path and bus checks
  // ****************************************
  a_bank1_read: assert property (
    loaded && !regs.wr_en && hsel && hready && htrans[1] && !hwrite
      && hsize == `BPT_HSIZE_WORD && NUM_BANKS > 1
      && haddr == {18'h0, `BPT_IDX_BANK1_P0, 2'h0}
      |=> hrdata == {24'h0, $past(trim0[1])})
    else $error("bank 1 0-degree trim read back wrongly");

  a_bank4_read: assert property (
    loaded && !regs.wr_en && hsel && hready && htrans[1] && !hwrite
      && hsize == `BPT_HSIZE_WORD && NUM_BANKS > 4
      && haddr == {18'h0, `BPT_IDX_BANK4_P90, 2'h0}
      |=> hrdata == {24'h0, $past(trim90[4])})
    else $error("bank 4 -90-degree trim read back wrongly");

  a_status_read: assert property (
    hsel && hready && htrans[1] && !hwrite && hsize == `BPT_HSIZE_WORD
      && haddr == {18'h0, `BPT_IDX_STATUS, 2'h0}
      |=> hrdata[`BPT_STAT_LOADED] == $past(loaded)
          && hrdata[`BPT_STAT_PHASE] == $past(phase_m90))
    else $error("status read does not show load and phase");

  a_bus_okay: assert property (
    hreadyout && hresp == `BPT_HRESP_OKAY)
    else $error("slave inserted a wait state or an error response");

  a_rdata_upper: assert property (
    hrdata[31:8] == 24'h0)
    else $error("read data above the 8-bit field is not zero");

  a_rdata_hold: assert property (
    !(hsel && hready && htrans[1]) |=> $stable(hrdata))
    else $error("read data changed without a transfer");

  a_stray_write: assert property (
    loaded && regs.wr_en && !trim_hit(regs.wr_idx) |=> $stable(trim0) && $stable(trim90))
    else $error("write to an unmapped place changed a trim");

  a_reset_clear: assert property (
    !loaded |-> trim0 == '0 && trim90 == '0 && bank_trim == '0)
    else $error("trims not cleared before the factory load");

  // ****************************************
  // Coverage
  // ****************************************
  c_write_trim:   cover property (loaded && regs.wr_en && trim_hit(regs.wr_idx));
  c_phase_toggle: cover property (loaded && $changed(phase_m90));
  c_read_status:  cover property (hsel && hready && htrans[1] && !hwrite
                                  && regs.rd_idx == `BPT_IDX_STATUS);
  c_factory_load: cover property ($rose(loaded));
  c_stray_write:  cover property (loaded && regs.wr_en && !trim_hit(regs.wr_idx));

endmodule

//--- bpt_cfg.svh
// Purpose: constants for the bank phase timing trim block
// Assumes: register indices are word indices, byte address is index times four
// Notes:   banks are numbered from 0, two trim registers per bank
//
// Overview of operation
// - 0-degree phase drives each bank's 0-degree trim
// - -90-degree phase drives each bank's -90-degree trim
// - Reset loads per-device factory trim, software overwrites
// - Each trim is 8-bit read/write, reads last value
// - Bank N trims decode at 0x1N2 and 0x1N3
`ifndef BPT_CFG_SVH
`define BPT_CFG_SVH

// ****************************************
// Register map (word indices)
// ****************************************
`define BPT_IDX_W          12
`define BPT_IDX_PAGE       4'h1
`define BPT_OFS_PHASE0     4'h2
`define BPT_OFS_PHASE90    4'h3
`define BPT_IDX_STATUS     12'h101
`define BPT_IDX_BANK0_P0   12'h102
`define BPT_IDX_BANK0_P90  12'h103
`define BPT_IDX_BANK1_P0   12'h112
`define BPT_IDX_BANK1_P90  12'h113
`define BPT_IDX_BANK2_P0   12'h122
`define BPT_IDX_BANK2_P90  12'h123
`define BPT_IDX_BANK3_P0   12'h132
`define BPT_IDX_BANK3_P90  12'h133
`define BPT_IDX_BANK4_P0   12'h142
`define BPT_IDX_BANK4_P90  12'h143

// ****************************************
// Field layout and reset values
// ****************************************
`define BPT_TRIM_W         8
`define BPT_TRIM_RST       8'h00
`define BPT_STAT_LOADED    0
`define BPT_STAT_PHASE     1
`define BPT_NUM_BANKS      5
`define BPT_MAX_BANKS      16

// ****************************************
// Bus encodings
// ****************************************
`define BPT_HTRANS_NONSEQ  2'h2
`define BPT_HSIZE_WORD     3'h2
`define BPT_HRESP_OKAY     1'h0

`endif

//--- bpt_pkg.sv
// Purpose: shared types of the bank phase timing trim block
// Assumes: nothing beyond the constants header
// Notes:   the phase type mirrors the converter's clock phase setting
package bpt_pkg;

  typedef logic [7:0] bpt_trim_t;

  typedef enum logic {
    BPT_PHASE_0,
    BPT_PHASE_M90
  } bpt_phase_t;

endpackage

//--- bpt_reg_if.sv
// Purpose: register access path between the bus slave and the trim store
// Assumes: one write and one read lookup per cycle at most
// Notes:   read data is combinational from the store
`timescale 1ns/1ps
interface bpt_reg_if;
  logic        wr_en;
  logic [11:0] wr_idx;
  logic [7:0]  wr_data;
  logic [11:0] rd_idx;
  logic [7:0]  rd_data;

  modport slv   (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

//--- bpt_ahb_slave.sv
// Purpose: AHB-Lite slave front end for the trim registers
// Assumes: single word transfers, zero wait states
// Notes:   read data is captured at the address phase edge
`timescale 1ns/1ps
`include "bpt_cfg.svh"
module bpt_ahb_slave
  import bpt_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Register path
  bpt_reg_if.slv           regs
);

  logic        req;
  logic        word_ok;
  logic        wr_pend;
  logic [11:0] wr_pend_idx;
  logic        next_wr_pend;
  logic [11:0] next_wr_pend_idx;
  logic [31:0] next_hrdata;

  // Misaligned, narrow or out-of-range accesses complete OKAY with no effect
  assign req     = hsel && hready && htrans[1];
  assign word_ok = (haddr[1:0] == 2'h0) && (hsize == `BPT_HSIZE_WORD)
                   && (haddr[31:14] == 18'h0);

  assign regs.rd_idx  = haddr[13:2];
  assign regs.wr_en   = wr_pend;
  assign regs.wr_idx  = wr_pend_idx;
  assign regs.wr_data = hwdata[7:0];

  always_comb begin
    next_wr_pend     = wr_pend;
    next_wr_pend_idx = wr_pend_idx;
    next_hrdata      = hrdata;
    if (hready) begin
      next_wr_pend = req && hwrite && word_ok;
      if (req) begin
        next_wr_pend_idx = haddr[13:2];
        next_hrdata      = (!hwrite && word_ok) ? {24'h0, regs.rd_data} : 32'h0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend     <= 1'b0;
      wr_pend_idx <= 12'h000;
      hrdata      <= 32'h0;
      hreadyout   <= 1'b1;
      hresp       <= `BPT_HRESP_OKAY;
    end else begin
      wr_pend     <= next_wr_pend;
      wr_pend_idx <= next_wr_pend_idx;
      hrdata      <= next_hrdata;
      hreadyout   <= 1'b1;
      hresp       <= `BPT_HRESP_OKAY;
    end
  end

endmodule

//--- bpt_trim_sel.sv
// Purpose: per-bank phase selection of the timing trim
// Assumes: trims and phase are in the bus clock domain
// Notes:   one register stage so the trim outputs are glitch free
`timescale 1ns/1ps
`include "bpt_cfg.svh"
module bpt_trim_sel
  import bpt_pkg::*;
#(
  parameter int NUM_BANKS = `BPT_NUM_BANKS
)
(
  // Clock and reset
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // Selection inputs
  input  bpt_phase_t                         phase,
  input  wire logic [NUM_BANKS-1:0][7:0]     trim0,
  input  wire logic [NUM_BANKS-1:0][7:0]     trim90,
  // Selected trims
  output logic      [NUM_BANKS-1:0][7:0]     bank_trim
);

  logic [NUM_BANKS-1:0][7:0] next_bank_trim;

  function automatic bpt_trim_t pick(bpt_phase_t ph, bpt_trim_t t0, bpt_trim_t t90);
    return (ph == BPT_PHASE_M90) ? t90 : t0;
  endfunction

  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      next_bank_trim[b] = pick(phase, trim0[b], trim90[b]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank_trim <= '0;
    end else begin
      bank_trim <= next_bank_trim;
    end
  end

endmodule

//--- bank_phase_timing_trim_tb_top.sv
// Purpose: self-checking bench for the bank phase timing trim store
// Assumes: single AHB-Lite slave, hready looped back from hreadyout
// Notes:   expected trims live in integer arrays, never read back from the design
`timescale 1ns/1ps
module bank_phase_timing_trim_tb_top;
  import bpt_pkg::*;

  localparam int NB = 5;

  logic                   hclk;
  logic                   hresetn;
  logic                   hsel;
  logic                   hwrite;
  logic                   phase_m90;
  logic [31:0]            haddr;
  logic [31:0]            hwdata;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  logic                   hreadyout;
  logic                   hresp;
  logic [31:0]            hrdata;
  logic [NB-1:0][7:0]     factory_trim0;
  logic [NB-1:0][7:0]     factory_trim90;
  logic [NB-1:0][7:0]     bank_trim;
  int                     num_errors;
  int                     comparisons;
  int                     exp0[NB];
  int                     exp90[NB];
  int                     exp_phase;
  int                     unmapped_q[$];
  logic [31:0]            rd;
  logic [31:0]            wd;

  bpt_top #(.NUM_BANKS(NB)) i_dut (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .hsel           (hsel),
    .haddr          (haddr),
    .htrans         (htrans),
    .hwrite         (hwrite),
    .hsize          (hsize),
    .hwdata         (hwdata),
    .hready         (hreadyout),
    .hreadyout      (hreadyout),
    .hresp          (hresp),
    .hrdata         (hrdata),
    .phase_m90      (phase_m90),
    .factory_trim0  (factory_trim0),
    .factory_trim90 (factory_trim90),
    .bank_trim      (bank_trim)
  );

  initial hclk = 1'b0;
  always #10 hclk = ~hclk;

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [11:0] idx(input int b, input int k);
    return 12'h100 + 12'(b * 16 + k);
  endfunction

  // Waits as long as the slave needs; the watchdog ends a hang
  task automatic wait_ready();
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask

  task automatic bus(input logic wr, input logic [11:0] ix, input logic [31:0] wdata,
                     output logic [31:0] rdata);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    haddr  <= {18'h0, ix, 2'h0};
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    wait_ready();
    rdata = hrdata;
  endtask

  task automatic reset_dut();
    hresetn <= 1'b0;
    repeat (11) @(posedge hclk);
    #1;
    chk("hreadyout_rst", {31'h0, hreadyout}, 32'h1);
    chk("hresp_rst", {31'h0, hresp}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    for (int b = 0; b < NB; b++) begin
      exp0[b]  = int'(factory_trim0[b]);
      exp90[b] = int'(factory_trim90[b]);
    end
  endtask

  task automatic check_outputs();
    #1;
    for (int b = 0; b < NB; b++) begin
      chk("bank_trim", 32'(bank_trim[b]), 32'(exp_phase ? exp90[b] : exp0[b]));
    end
    // Back on an edge so the next stimulus is launched there
    @(posedge hclk);
  endtask

  task automatic check_regs();
    for (int b = 0; b < NB; b++) begin
      bus(1'b0, idx(b, 2), 32'h0, rd);
      chk("trim0_reg", rd, 32'(exp0[b]));
      bus(1'b0, idx(b, 3), 32'h0, rd);
      chk("trim90_reg", rd, 32'(exp90[b]));
    end
  endtask

  task automatic new_factory();
    for (int b = 0; b < NB; b++) begin
      factory_trim0[b]  <= 8'($urandom_range(255));
      factory_trim90[b] <= 8'($urandom_range(255));
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int b;
    int k;
    void'($urandom(68346));
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    phase_m90 = 1'b0;
    exp_phase = 0;
    factory_trim0 = '0;
    factory_trim90 = '0;
    num_errors = 0;
    comparisons = 0;
    new_factory();
    reset_dut();
    check_outputs();
    check_regs();
    // Phase flip alone, no register traffic
    phase_m90 <= 1'b1;
    exp_phase = 1;
    @(posedge hclk);
    check_outputs();
    // Random writes, each read back at once, phase wandering meanwhile
    for (int i = 0; i < 24; i++) begin
      b = $urandom_range(NB - 1);
      k = 2 + $urandom_range(1);
      wd = $urandom;
      exp_phase = $urandom_range(1);
      phase_m90 <= exp_phase[0];
      bus(1'b1, idx(b, k), wd, rd);
      if (k == 2) begin
        exp0[b] = int'(wd[7:0]);
      end else begin
        exp90[b] = int'(wd[7:0]);
      end
      bus(1'b0, idx(b, k), 32'h0, rd);
      chk("readback", rd, {24'h0, wd[7:0]});
      @(posedge hclk);
      check_outputs();
    end
    // Reserved and absent-bank places take no write and read zero
    unmapped_q = '{32'h104, 32'h152, 32'h111};
    foreach (unmapped_q[j]) begin
      k = unmapped_q[j];
      bus(1'b1, 12'(k), 32'h0000_00A5, rd);
      bus(1'b0, 12'(k), 32'h0, rd);
      chk("unmapped", rd, 32'h0);
    end
    check_regs();
    bus(1'b0, 12'h101, 32'h0, rd);
    chk("status", rd, {30'h0, exp_phase[0], 1'b1});
    // Second reset reloads fresh factory trims over the written ones
    new_factory();
    reset_dut();
    check_regs();
    check_outputs();
    tally_and_finish();
  end

  initial begin
    repeat (6000) @(posedge hclk);
    num_errors++;
    tally_and_finish();
  end

endmodule
